/* File: pkg/fic_pkg.sv */
/*
 * Constants and register map of the framer interrupt and CI alarm block.
 * Assumes a 20 MHz clock and 32-bit APB data.
 */
// Function
// (RULE_01) policy 0: a status read clears the status bits it returned.
// (RULE_02) policy 1: status reads leave bits alone; writing one clears them.
// (RULE_03) auto clear 0: enables stay set after a status read.
// (RULE_04) auto clear 1: a status read drops the enables of bits it returned.
// (RULE_05) framer interrupt gate is the master enable of the interrupt output.
// (RULE_06) link select 00/11 picks controller one, 01 controller two, 10 three.
// (RULE_07) alarm generation and detection work only in extended superframe framing.
// (RULE_08) AIS-CI: all ones with 16-bit signature, right to left, every 386 bits.
// (RULE_09) RAI-CI cycle: 0.99 s of remote alarm message, then 90 ms signature.
// (RULE_10) RAI message 00000000 11111111, signature 00111110 11111111, right to left.
// (RULE_11) transmit field 00/11 disables generation, 10 enables RAI-CI; resets to 00.
// (RULE_12) detect field 00/11 disables, 01 enables AIS-CI, 10 enables RAI-CI detection.
// (RULE_13) transmit field 01 enables AIS-CI generation.
package fic_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_INT_CTRL = 12'h118;
    localparam logic [11:0] IDX_LINK_SEL = 12'h11B;
    localparam logic [11:0] IDX_CI_ALARM = 12'h11C;
    localparam logic [11:0] IDX_INT_STATUS = 12'h120;
    localparam logic [11:0] IDX_INT_ENABLE = 12'h121;
    localparam logic [11:0] IDX_CI_STATE = 12'h122;

    localparam logic [15:0] ADDR_INT_CTRL = {2'h0, IDX_INT_CTRL, 2'h0};
    localparam logic [15:0] ADDR_LINK_SEL = {2'h0, IDX_LINK_SEL, 2'h0};
    localparam logic [15:0] ADDR_CI_ALARM = {2'h0, IDX_CI_ALARM, 2'h0};
    localparam logic [15:0] ADDR_INT_STATUS = {2'h0, IDX_INT_STATUS, 2'h0};
    localparam logic [15:0] ADDR_INT_ENABLE = {2'h0, IDX_INT_ENABLE, 2'h0};
    localparam logic [15:0] ADDR_CI_STATE = {2'h0, IDX_CI_STATE, 2'h0};

    // interrupt control fields
    localparam int unsigned BIT_CLEAR_POLICY = 2;
    localparam int unsigned BIT_AUTO_CLEAR = 1;
    localparam int unsigned BIT_IRQ_GATE = 0;
    localparam logic [2:0] INT_CTRL_RST = 3'h0;
    localparam logic [1:0] LINK_SEL_RST = 2'h0;
    localparam logic [3:0] CI_ALARM_RST = 4'h0;

    // interrupt status / enable layout
    localparam int unsigned STAT_W = 2;
    localparam int unsigned STAT_AIS_CI = 0;
    localparam int unsigned STAT_RAI_CI = 1;

    // alarm field codes, shared by transmit [3:2] and detect [1:0]
    localparam logic [1:0] CI_CODE_AIS = 2'h1;
    localparam logic [1:0] CI_CODE_RAI = 2'h2;

    // link controller select codes
    localparam logic [1:0] LINK_CODE_TWO = 2'h1;
    localparam logic [1:0] LINK_CODE_THREE = 2'h2;

    // 16-bit words, bit 0 goes on the line first
    localparam logic [15:0] PAT_AIS_SIG = 16'h7CFF;
    localparam logic [15:0] PAT_RAI_MSG = 16'h00FF;
    localparam logic [15:0] PAT_RAI_SIG = 16'h3EFF;
    localparam logic [8:0] AIS_PERIOD_BITS = 9'd386;
    localparam logic [8:0] AIS_SIG_BITS = 9'd16;
    localparam logic [2:0] AIS_CONFIRM = 3'd4;

    // RAI-CI cycle timing
    localparam int unsigned RAI_MSG_MS = 990;
    localparam int unsigned RAI_SIG_MS = 90;
    localparam int unsigned RAI_MSG_CYC = RAI_MSG_MS * (CLK_HZ / 1000);
    localparam int unsigned RAI_SIG_CYC = RAI_SIG_MS * (CLK_HZ / 1000);
    localparam int unsigned TIME_CNT_W = 25;

    typedef enum logic [1:0] {
        FIC_GEN_IDLE = 2'b00,
        FIC_GEN_AIS = 2'b01,
        FIC_GEN_RAI_MSG = 2'b11,
        FIC_GEN_RAI_SIG = 2'b10
    } fic_gen_e;

endpackage

/* File: core/fic_pat_match.sv */
/*
 * Serial 16-bit matcher: pulses when the last sixteen bits equal the pattern.
 * Assumes strobes at least two clocks apart.
 */
`timescale 1ns/1ns
`default_nettype none
module fic_pat_match #(
    parameter logic [15:0] PATTERN = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_valid,
    input wire logic bit_in,
    output logic match
);
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic match_r;
    logic match_nxt;

    always_comb begin
        shift_nxt = shift_r;
        match_nxt = 1'b0;
        if (bit_valid) begin
            // first bit received ends up in bit 0
            shift_nxt = {bit_in, shift_r[15:1]};
            match_nxt = (shift_nxt == PATTERN);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 16'h0000;
            match_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            match_r <= match_nxt;
        end
    end

    assign match = match_r;
endmodule
`default_nettype wire

/* File: core/fic_top.sv */
/*
 * Framer interrupt control, data-link controller select and
 * customer-installation alarm generation/detection, behind an APB slave.
 * Assumes line bit strobes and framing mode come from framer logic on clk.
 */
`timescale 1ns/1ns
`default_nettype none
module fic_top #(
    parameter int unsigned RAI_MSG_CYC = fic_pkg::RAI_MSG_CYC,
    parameter int unsigned RAI_SIG_CYC = fic_pkg::RAI_SIG_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic framing_esf,
    input wire logic tx_bit_strobe,
    input wire logic tx_payload,
    output logic tx_line_data,
    output logic tx_ci_alarm_active,
    input wire logic rx_bit_strobe,
    input wire logic rx_line_data,
    output logic [2:0] dl_ctrl_sel
);
    // bus state
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic access, done, wr_done, rd_done;

    // registers
    logic [2:0] int_ctrl_r, int_ctrl_nxt;
    logic [1:0] link_sel_r, link_sel_nxt;
    logic [3:0] ci_alarm_r, ci_alarm_nxt;
    logic [fic_pkg::STAT_W-1:0] status_r, status_nxt;
    logic [fic_pkg::STAT_W-1:0] enable_r, enable_nxt;
    logic irq_r, irq_nxt;
    logic [2:0] dl_sel_r, dl_sel_nxt;

    // generator state
    fic_pkg::fic_gen_e gen_r, gen_nxt;
    logic [fic_pkg::TIME_CNT_W-1:0] time_r, time_nxt;
    logic [3:0] pat_idx_r, pat_idx_nxt;
    logic [8:0] ais_pos_r, ais_pos_nxt;
    logic tx_data_r, tx_data_nxt;
    logic tx_active_r, tx_active_nxt;

    // detector state
    logic [8:0] ais_gap_r, ais_gap_nxt;
    logic [2:0] ais_conf_r, ais_conf_nxt;
    logic msg_seen_r, msg_seen_nxt;
    logic ais_evt, rai_evt;
    logic m_ais_sig, m_rai_msg, m_rai_sig;
    logic det_ais, det_rai;
    logic [fic_pkg::STAT_W-1:0] evt;

    assign access = psel && penable;
    assign done = access && pready_r;
    assign wr_done = done && pwrite;
    assign rd_done = done && !pwrite;

    // APB: one wait state, read data and error captured before completion
    always_comb begin
        pready_nxt = access && !pready_r;
        pslverr_nxt = pslverr_r;
        prdata_nxt = prdata_r;
        if (access && !pready_r) begin
            pslverr_nxt = 1'b0;
            prdata_nxt = 32'h0000_0000;
            if (paddr == fic_pkg::ADDR_INT_CTRL) begin
                prdata_nxt[2:0] = int_ctrl_r;
            end else if (paddr == fic_pkg::ADDR_LINK_SEL) begin
                prdata_nxt[1:0] = link_sel_r;
            end else if (paddr == fic_pkg::ADDR_CI_ALARM) begin
                prdata_nxt[3:0] = ci_alarm_r;
            end else if (paddr == fic_pkg::ADDR_INT_STATUS) begin
                prdata_nxt[fic_pkg::STAT_W-1:0] = status_r;
            end else if (paddr == fic_pkg::ADDR_INT_ENABLE) begin
                prdata_nxt[fic_pkg::STAT_W-1:0] = enable_r;
            end else if (paddr == fic_pkg::ADDR_CI_STATE) begin
                prdata_nxt[3:0] = {ais_conf_r == fic_pkg::AIS_CONFIRM, tx_active_r, gen_r};
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // register file with status side effects
    always_comb begin
        int_ctrl_nxt = int_ctrl_r;
        link_sel_nxt = link_sel_r;
        ci_alarm_nxt = ci_alarm_r;
        status_nxt = status_r;
        enable_nxt = enable_r;
        if (wr_done) begin
            if (paddr == fic_pkg::ADDR_INT_CTRL) begin
                int_ctrl_nxt = pwdata[2:0];
            end else if (paddr == fic_pkg::ADDR_LINK_SEL) begin
                link_sel_nxt = pwdata[1:0];
            end else if (paddr == fic_pkg::ADDR_CI_ALARM) begin
                ci_alarm_nxt = pwdata[3:0];
            end else if (paddr == fic_pkg::ADDR_INT_ENABLE) begin
                enable_nxt = pwdata[fic_pkg::STAT_W-1:0];
            end else if (paddr == fic_pkg::ADDR_INT_STATUS && int_ctrl_r[fic_pkg::BIT_CLEAR_POLICY]) begin
                status_nxt = status_r & ~pwdata[fic_pkg::STAT_W-1:0]; // [RULE_02]
            end
        end
        // only bits actually returned are cleared, so nothing unread is lost
        if (rd_done && paddr == fic_pkg::ADDR_INT_STATUS) begin
            if (!int_ctrl_r[fic_pkg::BIT_CLEAR_POLICY]) begin
                status_nxt = status_r & ~prdata_r[fic_pkg::STAT_W-1:0]; // [RULE_01]
            end
            if (int_ctrl_r[fic_pkg::BIT_AUTO_CLEAR]) begin
                enable_nxt = enable_r & ~prdata_r[fic_pkg::STAT_W-1:0]; // [RULE_04]
            end // enables otherwise untouched by reads [RULE_03]
        end
        status_nxt = status_nxt | evt; // set wins over clear
        irq_nxt = int_ctrl_r[fic_pkg::BIT_IRQ_GATE] && |(status_r & enable_r); // [RULE_05]
        if (link_sel_r == fic_pkg::LINK_CODE_TWO) begin // [RULE_06]
            dl_sel_nxt = 3'b010;
        end else if (link_sel_r == fic_pkg::LINK_CODE_THREE) begin
            dl_sel_nxt = 3'b100;
        end else begin
            dl_sel_nxt = 3'b001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ctrl_r <= fic_pkg::INT_CTRL_RST;
            link_sel_r <= fic_pkg::LINK_SEL_RST;
            ci_alarm_r <= fic_pkg::CI_ALARM_RST; // [RULE_11]
            status_r <= '0;
            enable_r <= '0;
            irq_r <= 1'b0;
            dl_sel_r <= 3'b001;
        end else begin
            int_ctrl_r <= int_ctrl_nxt;
            link_sel_r <= link_sel_nxt;
            ci_alarm_r <= ci_alarm_nxt;
            status_r <= status_nxt;
            enable_r <= enable_nxt;
            irq_r <= irq_nxt;
            dl_sel_r <= dl_sel_nxt;
        end
    end

    // alarm generator
    always_comb begin
        gen_nxt = gen_r;
        time_nxt = time_r + 1'b1;
        pat_idx_nxt = pat_idx_r;
        ais_pos_nxt = ais_pos_r;
        tx_data_nxt = tx_data_r;
        case (gen_r)
            fic_pkg::FIC_GEN_AIS: begin
                if (!framing_esf || ci_alarm_r[3:2] != fic_pkg::CI_CODE_AIS) begin
                    gen_nxt = fic_pkg::FIC_GEN_IDLE;
                end
            end
            fic_pkg::FIC_GEN_RAI_MSG: begin
                if (!framing_esf || ci_alarm_r[3:2] != fic_pkg::CI_CODE_RAI) begin
                    gen_nxt = fic_pkg::FIC_GEN_IDLE;
                end else if (time_r == fic_pkg::TIME_CNT_W'(RAI_MSG_CYC - 1)) begin
                    gen_nxt = fic_pkg::FIC_GEN_RAI_SIG; // [RULE_09]
                end
            end
            fic_pkg::FIC_GEN_RAI_SIG: begin
                if (!framing_esf || ci_alarm_r[3:2] != fic_pkg::CI_CODE_RAI) begin
                    gen_nxt = fic_pkg::FIC_GEN_IDLE;
                end else if (time_r == fic_pkg::TIME_CNT_W'(RAI_SIG_CYC - 1)) begin
                    gen_nxt = fic_pkg::FIC_GEN_RAI_MSG; // [RULE_09]
                end
            end
            default: begin
                // codes 00 and 11 keep the generator idle [RULE_11]
                if (framing_esf && ci_alarm_r[3:2] == fic_pkg::CI_CODE_AIS) begin // [RULE_07]
                    gen_nxt = fic_pkg::FIC_GEN_AIS; // [RULE_13]
                end else if (framing_esf && ci_alarm_r[3:2] == fic_pkg::CI_CODE_RAI) begin
                    gen_nxt = fic_pkg::FIC_GEN_RAI_MSG; // [RULE_11]
                end
            end
        endcase
        if (gen_nxt != gen_r) begin
            time_nxt = '0;
            pat_idx_nxt = 4'h0;
            ais_pos_nxt = 9'd0;
        end else if (tx_bit_strobe) begin
            pat_idx_nxt = pat_idx_r + 4'h1;
            ais_pos_nxt = (ais_pos_r == fic_pkg::AIS_PERIOD_BITS - 9'd1) ? 9'd0 : ais_pos_r + 9'd1;
            case (gen_r)
                fic_pkg::FIC_GEN_AIS: begin
                    // signature in the first sixteen positions, ones elsewhere [RULE_08]
                    tx_data_nxt = (ais_pos_r < fic_pkg::AIS_SIG_BITS) ? fic_pkg::PAT_AIS_SIG[ais_pos_r[3:0]] : 1'b1;
                end
                fic_pkg::FIC_GEN_RAI_MSG: tx_data_nxt = fic_pkg::PAT_RAI_MSG[pat_idx_r]; // [RULE_10]
                fic_pkg::FIC_GEN_RAI_SIG: tx_data_nxt = fic_pkg::PAT_RAI_SIG[pat_idx_r]; // [RULE_10]
                default: tx_data_nxt = tx_payload;
            endcase
        end
        tx_active_nxt = (gen_r != fic_pkg::FIC_GEN_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_r <= fic_pkg::FIC_GEN_IDLE;
            time_r <= '0;
            pat_idx_r <= 4'h0;
            ais_pos_r <= 9'd0;
            tx_data_r <= 1'b1;
            tx_active_r <= 1'b0;
        end else begin
            gen_r <= gen_nxt;
            time_r <= time_nxt;
            pat_idx_r <= pat_idx_nxt;
            ais_pos_r <= ais_pos_nxt;
            tx_data_r <= tx_data_nxt;
            tx_active_r <= tx_active_nxt;
        end
    end

    // alarm detectors
    assign det_ais = framing_esf && ci_alarm_r[1:0] == fic_pkg::CI_CODE_AIS; // [RULE_07] [RULE_12]
    assign det_rai = framing_esf && ci_alarm_r[1:0] == fic_pkg::CI_CODE_RAI; // [RULE_07] [RULE_12]

    fic_pat_match #(.PATTERN(fic_pkg::PAT_AIS_SIG)) u_ais_sig (
        .clk(clk),
        .rst_n(rst_n),
        .bit_valid(rx_bit_strobe && det_ais),
        .bit_in(rx_line_data),
        .match(m_ais_sig)
    );

    fic_pat_match #(.PATTERN(fic_pkg::PAT_RAI_MSG)) u_rai_msg (
        .clk(clk),
        .rst_n(rst_n),
        .bit_valid(rx_bit_strobe && det_rai),
        .bit_in(rx_line_data),
        .match(m_rai_msg)
    );

    fic_pat_match #(.PATTERN(fic_pkg::PAT_RAI_SIG)) u_rai_sig (
        .clk(clk),
        .rst_n(rst_n),
        .bit_valid(rx_bit_strobe && det_rai),
        .bit_in(rx_line_data),
        .match(m_rai_sig)
    );

    always_comb begin
        ais_gap_nxt = ais_gap_r;
        ais_conf_nxt = ais_conf_r;
        msg_seen_nxt = msg_seen_r;
        ais_evt = 1'b0;
        rai_evt = 1'b0;
        if (!det_ais) begin
            ais_gap_nxt = 9'd0;
            ais_conf_nxt = 3'd0;
        end else if (m_ais_sig) begin
            // signature must recur exactly one period after the last one [RULE_08]
            ais_gap_nxt = 9'd0;
            if (ais_gap_r != fic_pkg::AIS_PERIOD_BITS) begin
                ais_conf_nxt = 3'd1;
            end else if (ais_conf_r != fic_pkg::AIS_CONFIRM) begin
                ais_conf_nxt = ais_conf_r + 3'd1;
                ais_evt = (ais_conf_nxt == fic_pkg::AIS_CONFIRM);
            end
        end else if (rx_bit_strobe && ais_gap_r <= fic_pkg::AIS_PERIOD_BITS) begin
            ais_gap_nxt = ais_gap_r + 9'd1;
        end
        // limitation: one message word followed later by a signature counts
        if (!det_rai) begin
            msg_seen_nxt = 1'b0;
        end else if (m_rai_sig && msg_seen_r) begin
            rai_evt = 1'b1; // [RULE_10]
            msg_seen_nxt = 1'b0;
        end else if (m_rai_msg) begin
            msg_seen_nxt = 1'b1;
        end
        evt = '0;
        evt[fic_pkg::STAT_AIS_CI] = ais_evt;
        evt[fic_pkg::STAT_RAI_CI] = rai_evt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ais_gap_r <= 9'd0;
            ais_conf_r <= 3'd0;
            msg_seen_r <= 1'b0;
        end else begin
            ais_gap_r <= ais_gap_nxt;
            ais_conf_r <= ais_conf_nxt;
            msg_seen_r <= msg_seen_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign tx_line_data = tx_data_r;
    assign tx_ci_alarm_active = tx_active_r;
    assign dl_ctrl_sel = dl_sel_r;
endmodule
`default_nettype wire

/* File: verification/fic_sva.sv */
/*
 * Port assertions for fic_top.
 * Assumes requests held until pready.
 */
`timescale 1ns/1ns
`default_nettype none
module fic_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic framing_esf,
    input wire logic tx_bit_strobe,
    input wire logic tx_payload,
    input wire logic tx_line_data,
    input wire logic tx_ci_alarm_active,
    input wire logic [2:0] dl_ctrl_sel
);
    logic done, mapped;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [1:0] nesf_r, nesf_nxt;
    assign done = psel && penable && pready;
    assign mapped = paddr inside {fic_pkg::ADDR_INT_CTRL, fic_pkg::ADDR_LINK_SEL, fic_pkg::ADDR_CI_ALARM,
        fic_pkg::ADDR_INT_STATUS, fic_pkg::ADDR_INT_ENABLE, fic_pkg::ADDR_CI_STATE};
    // shadow of the control word
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (done && pwrite && paddr == fic_pkg::ADDR_INT_CTRL) begin
            ctrl_nxt = pwdata[2:0];
        end
        nesf_nxt = framing_esf ? 2'h0 : ((nesf_r == 2'h3) ? nesf_r : nesf_r + 2'h1);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= 3'h0;
            nesf_r <= 2'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            nesf_r <= nesf_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait_then_ready;
        (psel && penable && !pready) ##1 (psel && penable && pready);
    endsequence
    property p_sel;
        logic [1:0] c;
        (done && pwrite && paddr == fic_pkg::ADDR_LINK_SEL, c = pwdata[1:0]) |-> ##2
            dl_ctrl_sel == ((c == 2'h1) ? 3'h2 : ((c == 2'h2) ? 3'h4 : 3'h1));
    endproperty
    AST_APB_WAIT: assert property (s_setup |=> s_wait_then_ready)
        else $error("no single wait state");
    AST_SLVERR: assert property (pready |-> pslverr == !mapped)
        else $error("bad slave error");
    AST_LINK_SEL: assert property (p_sel)
        else $error("bad link select");
    AST_IRQ_GATE: assert property (!ctrl_r[0] |=> !irq)
        else $error("irq while gated");
    AST_TX_HOLD: assert property (!tx_bit_strobe |=> $stable(tx_line_data))
        else $error("line bit moved");
    AST_NESF_IDLE: assert property (nesf_r == 2'h3 |-> !tx_ci_alarm_active)
        else $error("alarm outside esf");
    AST_NESF_PAY: assert property (nesf_r == 2'h3 && tx_bit_strobe |=> tx_line_data == $past(tx_payload))
        else $error("payload lost");
    AST_ROSE_ESF: assert property ($rose(tx_ci_alarm_active) |-> $past(framing_esf) || $past(framing_esf, 2))
        else $error("alarm start without esf");
endmodule
bind fic_top fic_sva u_sva (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq), .framing_esf(framing_esf),
    .tx_bit_strobe(tx_bit_strobe), .tx_payload(tx_payload), .tx_line_data(tx_line_data),
    .tx_ci_alarm_active(tx_ci_alarm_active), .dl_ctrl_sel(dl_ctrl_sel));
`default_nettype wire

/* File: verification/fic_line_model.sv */
/*
 * Line partner: bit strobes, alarm streams, transmit capture.
 * Assumes the clock of fic_top.
 */
`timescale 1ns/1ns
`default_nettype none
module fic_line_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic tx_line_data,
    output logic tx_bit_strobe,
    output logic rx_bit_strobe,
    output logic rx_line_data,
    output logic [15:0] tx_last16,
    output logic [31:0] tx_count
);
    logic [1:0] ph = 2'h0;
    logic [8:0] pos = 9'h0;
    logic [5:0] wb = 6'h0;
    logic cap = 1'b0;
    wire [15:0] w = (mode == 2'h1) ? 16'h7CFF : (wb[5] ? 16'h3EFF : 16'h00FF);
    initial begin
        tx_bit_strobe = 1'b0;
        rx_bit_strobe = 1'b0;
        rx_line_data = 1'b1;
        tx_last16 = 16'h0;
        tx_count = 32'h0;
    end
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        tx_bit_strobe <= rst_n && ph == 2'h0;
        rx_bit_strobe <= rst_n && ph == 2'h2;
        cap <= tx_bit_strobe;
        if (cap) begin
            tx_last16 <= {tx_line_data, tx_last16[15:1]};
            tx_count <= tx_count + 32'h1;
        end
        if (rst_n && ph == 2'h2) begin
            pos <= (pos == 9'd385) ? 9'h0 : pos + 9'h1;
            wb <= wb + 6'h1;
            case (mode)
                2'h1: rx_line_data <= (pos < 9'd16) ? w[pos[3:0]] : 1'b1;
                2'h2: rx_line_data <= w[wb[3:0]];
                default: rx_line_data <= pos[0];
            endcase
        end else begin
            // no stale level between strobes
            rx_line_data <= ~rx_line_data;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * Bench for fic_top with the line partner.
 * Assumes the checker binds itself.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [15:0] CTL = fic_pkg::ADDR_INT_CTRL;
    localparam logic [15:0] STA = fic_pkg::ADDR_INT_STATUS;
    localparam logic [15:0] ENA = fic_pkg::ADDR_INT_ENABLE;
    localparam logic [15:0] CIA = fic_pkg::ADDR_CI_ALARM;
    localparam logic [15:0] AD [4] = '{CTL, fic_pkg::ADDR_LINK_SEL, CIA, ENA};
    localparam logic [31:0] MK [4] = '{32'h7, 32'h3, 32'hF, 32'h3};
    localparam logic [31:0] SELX [4] = '{32'h1, 32'h2, 32'h4, 32'h1};
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, framing_esf = 1'b0, tx_payload = 1'b0;
    logic [15:0] paddr = 16'h0, tx_last16;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] mode = 2'h0;
    logic pready, pslverr, irq, tx_bit_strobe, rx_bit_strobe, rx_line_data, tx_line_data, tx_ci_alarm_active;
    logic [31:0] prdata, tx_count, n0, n1;
    logic [2:0] dl_ctrl_sel;
    logic [33:0] exp_q[$], e;
    int errors = 0, checks_done = 0;
    fic_top #(.RAI_MSG_CYC(400), .RAI_SIG_CYC(160)) DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .framing_esf(framing_esf), .tx_bit_strobe(tx_bit_strobe),
        .tx_payload(tx_payload), .tx_line_data(tx_line_data), .tx_ci_alarm_active(tx_ci_alarm_active),
        .rx_bit_strobe(rx_bit_strobe), .rx_line_data(rx_line_data), .dl_ctrl_sel(dl_ctrl_sel));
    fic_line_model u_line (.clk(clk), .rst_n(rst_n), .mode(mode), .tx_line_data(tx_line_data),
        .tx_bit_strobe(tx_bit_strobe), .rx_bit_strobe(rx_bit_strobe), .rx_line_data(rx_line_data),
        .tx_last16(tx_last16), .tx_count(tx_count));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic bail(input logic ok);
        if (!ok) begin
            errors++;
            $display("Error at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    // m: 1 check data, 2 expect slave error
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] x,
            input int m);
        int i;
        exp_q.push_back({m == 1, m == 2, x});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
        bail(i < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 0);
    endtask
    task automatic wirq(input int n);
        int i;
        for (i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
        bail(i < n);
    endtask
    task automatic wpat(input logic [15:0] p, output logic [31:0] c);
        int i;
        logic [31:0] last;
        last = tx_count;
        for (i = 0; i < 4000; i++) begin
            @(posedge clk);
            if (tx_count != last && tx_last16 === p) break;
            last = tx_count;
        end
        bail(i < 4000);
        c = tx_count;
    endtask
    always @(posedge clk) begin
        tx_payload <= 1'($urandom());
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
            chk({31'h0, pslverr}, {31'h0, e[32]});
            if (e[33]) chk(prdata, e[31:0]);
        end
    end
    initial begin
        void'($urandom(82187));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(AD[i], 32'h0);
            n0 = $urandom();
            wr(AD[i], n0);
            rd(AD[i], n0 & MK[i]);
            wr(AD[i], 32'h0);
        end
        rd(STA, 32'h0);
        apb(1'b0, 16'h0FF0, 32'h0, 32'h0, 2);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            wr(fic_pkg::ADDR_LINK_SEL, 32'(i));
            @(posedge clk);
            chk({29'h0, dl_ctrl_sel}, SELX[i]);
        end
        $display("link select done");
        framing_esf <= 1'b1;
        wr(ENA, 32'h1);
        wr(CTL, 32'h3);
        wr(CIA, 32'h1);
        mode <= 2'h1;
        wirq(20000);
        rd(STA, 32'h1);
        rd(STA, 32'h0);
        rd(ENA, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("clear on read done");
        mode <= 2'h0;
        wr(CIA, 32'h2);
        wr(ENA, 32'h2);
        wr(CTL, 32'h5);
        mode <= 2'h2;
        wirq(3000);
        mode <= 2'h0;
        rd(STA, 32'h2);
        rd(STA, 32'h2);
        rd(ENA, 32'h2);
        wr(CTL, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(CTL, 32'h5);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(STA, 32'h2);
        rd(STA, 32'h0);
        $display("write to clear done");
        for (int i = 0; i < 4; i++) begin
            wr(CIA, 32'(i) << 2);
            repeat (4) @(posedge clk);
            chk({31'h0, tx_ci_alarm_active}, {31'h0, i == 1 || i == 2});
        end
        wr(CIA, 32'h4);
        wpat(16'h7CFF, n0);
        wpat(16'h7CFF, n1);
        chk(n1 - n0, 32'd386);
        wr(CIA, 32'h8);
        wpat(16'h00FF, n0);
        wpat(16'h3EFF, n1);
        chk({16'h0, tx_last16}, 32'h3EFF);
        wpat(16'h00FF, n0);
        chk({16'h0, tx_last16}, 32'h00FF);
        $display("generation done");
        framing_esf <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, tx_ci_alarm_active}, 32'h0);
        repeat (40) @(posedge clk);
        $display("framing done");
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bail(1'b0);
    end
endmodule
`default_nettype wire
